// ==== rtl/loop_buffer_pkg.sv ====
// shared constants and enumerations of the loop buffer controller
// assumes one core clock; every importer sees the same widths
package loop_buffer_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int BUF_DEPTH  = 14;
  localparam int MAX_BODY   = 48;
  localparam int PRED_DELAY = 3;
  localparam int SLOT_W     = 6;
  localparam int OFS_W      = 6;
  localparam int PACKET_W   = 32;

  // ----------------------------------------------------------------
  // fixed values
  // ----------------------------------------------------------------
  localparam logic [SLOT_W-1:0] SLOT_ZERO = 6'h00;
  localparam logic [SLOT_W-1:0] SLOT_ONE  = 6'h01;
  localparam logic [OFS_W-1:0]  OFS_ZERO  = 6'h00;
  localparam logic [OFS_W-1:0]  OFS_ONE   = 6'h01;
  localparam logic [OFS_W-1:0]  OFS_LAST  = 6'(MAX_BODY - 1);

  // ----------------------------------------------------------------
  // enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_COUNTED = 2'h0,
    KIND_DELAYED = 2'h1,
    KIND_WHILE   = 2'h2
  } loop_kind_type;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_LOAD   = 2'h1,
    PH_KERNEL = 2'h2,
    PH_DRAIN  = 2'h3
  } phase_type;

endpackage : loop_buffer_pkg

// ==== rtl/loop_stage_timer.sv ====
// buffer slot index counter that marks stage boundaries
// assumes ii is at least one while running
`timescale 1ns/100ps
`default_nettype none

module loop_stage_timer
  import loop_buffer_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  stage_if.timer    st_if
);

  typedef struct packed {
    logic [SLOT_W-1:0] slot;
  } timer_state_type;

  timer_state_type st;
  timer_state_type next_st;

  // ----------------------------------------------------------------
  // slot index
  // ----------------------------------------------------------------
  assign st_if.slot     = st.slot;
  assign st_if.boundary = !st_if.restart && !st_if.hold
                          && (st.slot >= st_if.ii - SLOT_ONE);

  always_comb
  begin
    next_st = st;
    if (st_if.restart)
      next_st.slot = SLOT_ZERO;
    else if (!st_if.hold)
    begin
      if (st.slot >= st_if.ii - SLOT_ONE)
        next_st.slot = SLOT_ZERO;
      else
        next_st.slot = st.slot + SLOT_ONE;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : loop_stage_timer

`default_nettype wire

// ==== rtl/predicate_delay.sv ====
// fixed delay line for the while-loop exit condition
// assumes the input comes from core-clock logic
`timescale 1ns/100ps
`default_nettype none

module predicate_delay
  import loop_buffer_pkg::*;
#(
  parameter int DEPTH = PRED_DELAY
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic condIn,
  output var  logic condOut
);

  typedef struct packed {
    logic [DEPTH-1:0] line;
  } delay_state_type;

  delay_state_type st;
  delay_state_type next_st;

  if (DEPTH < 1) begin : g_bad_depth
    $error("predicate delay needs at least one stage");
  end

  // ----------------------------------------------------------------
  // delay line
  // ----------------------------------------------------------------
  // three cycle lag
  always_comb
  begin
    next_st = st;
    next_st.line = DEPTH'({st.line, condIn});
  end

  assign condOut = st.line[DEPTH-1];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

endmodule : predicate_delay

`default_nettype wire

// ==== rtl/software_pipelined_loop_buffer.sv ====
// loop buffer controller for hardware software-pipelined loops
// assumes the fetch path reports each body cycle and stalls on the
// core clock; issue from the buffer runs beside program memory
//
// What this block does
// - while loop counts on predicate, not count
// - test exit condition on every stage boundary
// - while loop exits with no epilog
// - exit three cycles after predicate reaches zero
// - overlapped unfinished iterations are abandoned
// - buffer holds at most fourteen packets
// - capture from start to kernel end packet
// - stages are ii-cycle shifted copies of body
// - body length counts packets and nops, not stalls
// - body length at most forty-eight cycles
// - capture on first pass, kernel from buffer
// - epilog drains entries in load order
// - memory feeds newest stage until kernel end
// - boundary every ii cycles, first is loading
// - first boundary at or after kernel end
// - last kernel boundary precedes epilog only
// - slot index wraps to zero at ii
// - loaded packet valid from next cycle
// - active flag high while buffer active
`timescale 1ns/100ps
`default_nettype none

module software_pipelined_loop_buffer
  import loop_buffer_pkg::*;
#(
  parameter int DEPTH = BUF_DEPTH,
  parameter int PKT_W = PACKET_W
)
(
  input  wire logic                         clk,
  input  wire logic                         rstn,
  input  wire logic                         startValid,
  input  wire loop_buffer_pkg::loop_kind_type startKind,
  input  wire logic [SLOT_W-1:0]            startIi,
  input  wire logic                         fetchValid,
  input  wire logic [PKT_W-1:0]             fetchPacket,
  input  wire logic                         kernelEnd,
  input  wire logic                         stall,
  input  wire logic                         countZero,
  input  wire logic                         predicateZero,
  output var  logic                         memFetchEnable,
  output var  logic [DEPTH-1:0]             bufIssueMask,
  output var  logic [DEPTH-1:0][PKT_W-1:0]  bufPacket,
  output var  logic [SLOT_W-1:0]            slotIndex,
  output var  logic                         stageBoundary,
  output var  logic                         firstLoadBoundary,
  output var  logic                         firstKernelBoundary,
  output var  logic                         lastKernelBoundary,
  output var  logic                         bufferActive,
  output var  logic                         loadOverflow
);

  if (DEPTH < 1 || DEPTH > BUF_DEPTH || PKT_W < 1) begin : g_bad_cfg
    $error("loop buffer depth or packet width out of range");
  end

  localparam int PTR_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_FULL = PTR_W'(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [OFS_W-1:0]  offset;
    logic [PKT_W-1:0]  packet;
  } entry_type;

  typedef struct packed {
    phase_type              phase;
    logic                   isWhile;
    logic                   kernelSeen;
    logic                   fetchBegun;
    logic                   overflow;
    logic [SLOT_W-1:0]      ii;
    logic [OFS_W-1:0]       loadCount;
    logic [OFS_W-1:0]       dynlen;
    logic [OFS_W-1:0]       drainCount;
    logic [PTR_W-1:0]       writePtr;
    entry_type [DEPTH-1:0]  entries;
  } ctrl_state_type;

  ctrl_state_type st;
  ctrl_state_type next_st;
  logic           predDelayed;
  logic           bnd;
  logic           endNow;

  stage_if stg ();

  // ----------------------------------------------------------------
  // stage timing
  // ----------------------------------------------------------------
  loop_stage_timer u_timer (
    .clk   (clk),
    .rstn  (rstn),
    .st_if (stg)
  );

  predicate_delay #(.DEPTH(PRED_DELAY)) u_pred (
    .clk     (clk),
    .rstn    (rstn),
    .condIn  (predicateZero),
    .condOut (predDelayed)
  );

  assign stg.restart = (st.phase == PH_IDLE) && startValid;
  assign stg.hold    = stall;
  assign stg.ii      = st.ii;

  assign bnd    = stg.boundary && (st.phase != PH_IDLE);
  assign endNow = fetchValid && kernelEnd && !st.kernelSeen;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign slotIndex         = stg.slot;
  assign stageBoundary     = bnd;
  assign firstLoadBoundary = bnd && (st.phase == PH_LOAD)
                             && !st.fetchBegun;
  assign firstKernelBoundary = bnd && (st.phase == PH_LOAD)
                               && (st.kernelSeen || endNow);
  assign lastKernelBoundary = bnd && (st.phase == PH_KERNEL)
                              && !st.isWhile && countZero;
  // memory feeds only until kernel end
  assign memFetchEnable = (st.phase == PH_LOAD) && !st.kernelSeen;
  assign bufferActive   = (st.phase != PH_IDLE);
  assign loadOverflow   = st.overflow;

  // issue copies whose slot matches the index
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      bufIssueMask[i] = st.entries[i].valid && st.fetchBegun && !stall
                        && (st.entries[i].slot == stg.slot)
                        && !((st.phase == PH_DRAIN)
                             && (st.entries[i].offset == st.drainCount));
      bufPacket[i]    = st.entries[i].packet;
    end
  end

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    if (st.phase == PH_IDLE)
    begin
      if (startValid)
      begin
        next_st         = '0;
        next_st.phase   = PH_LOAD;
        next_st.isWhile = (startKind == KIND_WHILE);
        next_st.ii      = (startIi == SLOT_ZERO) ? SLOT_ONE : startIi;
      end
    end
    else if (!stall)
    begin
      case (st.phase)
        PH_LOAD:
        begin
          if (fetchValid && !st.kernelSeen)
          begin
            if (st.writePtr == PTR_FULL)
            begin
              next_st.overflow = 1'b1;
              next_st.phase    = PH_IDLE;
            end
            else
            begin
              next_st.entries[st.writePtr].valid  = 1'b1;
              next_st.entries[st.writePtr].slot   = stg.slot;
              next_st.entries[st.writePtr].offset = st.loadCount;
              next_st.entries[st.writePtr].packet = fetchPacket;
              next_st.writePtr = st.writePtr + PTR_ONE;
            end
          end
          if (endNow)
          begin
            next_st.kernelSeen = 1'b1;
            next_st.dynlen     = st.loadCount + OFS_ONE;
          end
          else if (!st.kernelSeen)
          begin
            if (st.loadCount == OFS_LAST)
            begin
              next_st.overflow = 1'b1;
              next_st.phase    = PH_IDLE;
            end
            else
              next_st.loadCount = st.loadCount + OFS_ONE;
          end
          if (bnd)
          begin
            next_st.fetchBegun = 1'b1;
            if (st.kernelSeen || endNow)
              next_st.phase = PH_KERNEL;
            if (st.isWhile && predDelayed)
              next_st.phase = PH_IDLE;
          end
        end
        PH_KERNEL:
        begin
          if (bnd)
          begin
            if (st.isWhile && predDelayed)
              next_st.phase = PH_IDLE;
            else if (!st.isWhile && countZero)
            begin
              next_st.phase      = PH_DRAIN;
              next_st.drainCount = OFS_ZERO;
            end
          end
        end
        PH_DRAIN:
        begin
          for (int i = 0; i < DEPTH; i++)
            if (st.entries[i].offset == st.drainCount)
              next_st.entries[i].valid = 1'b0;
          next_st.drainCount = st.drainCount + OFS_ONE;
          if (st.drainCount >= st.dynlen - OFS_ONE)
            next_st.phase = PH_IDLE;
        end
        default:
          next_st.phase = PH_IDLE;
      endcase
    end
    if (next_st.phase == PH_IDLE)
    begin
      for (int i = 0; i < DEPTH; i++)
        next_st.entries[i].valid = 1'b0;
      next_st.fetchBegun = 1'b0;
      next_st.kernelSeen = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st <= '0;
    else
      st <= next_st;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [1:0] age;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      age <= 2'h0;
    else if (age != 2'h3)
      age <= age + 2'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_while_ignores_count: assert property (
    (st.phase == PH_KERNEL) && st.isWhile && bnd && countZero
    && !predDelayed && !stall |=> st.phase == PH_KERNEL)
    else $error("while loop drained on count");
  a_while_boundary_exit: assert property (
    (st.phase != PH_IDLE) && st.isWhile && bnd && predDelayed
    && !stall |=> st.phase == PH_IDLE)
    else $error("while loop missed exit at boundary");
  a_while_no_drain: assert property (
    st.isWhile |-> st.phase != PH_DRAIN)
    else $error("while loop entered epilog");
  a_pred_three_cycles: assert property (
    (age == 2'h3) |-> predDelayed == $past(predicateZero, 3))
    else $error("exit condition lag is not three cycles");
  a_idle_no_issue: assert property (
    (st.phase == PH_IDLE) |-> bufIssueMask == '0)
    else $error("issue from idle buffer");
  a_depth_bound: assert property (
    st.writePtr <= PTR_FULL)
    else $error("buffer write pointer past depth");
  a_kernel_from_buffer: assert property (
    (st.phase != PH_LOAD) |-> !memFetchEnable)
    else $error("program memory feeds past loading");
  a_slot_wraps: assert property (
    (st.phase != PH_IDLE) && !stall && (stg.slot == st.ii - SLOT_ONE)
    |=> stg.slot == SLOT_ZERO)
    else $error("slot index did not wrap at ii");
  a_load_valid_next: assert property (
    (st.phase == PH_LOAD) && fetchValid && !stall && !st.kernelSeen
    && (st.writePtr < PTR_FULL) && !(bnd && st.isWhile && predDelayed)
    |=> st.entries[$past(st.writePtr)].valid)
    else $error("loaded packet not valid next cycle");
  a_active_flag: assert property (
    $rose(bufferActive) |-> $past(startValid))
    else $error("buffer became active without start");

  c_while_exit: cover property (
    st.isWhile && (st.phase == PH_KERNEL) ##1 st.phase == PH_IDLE);
  c_drain_done: cover property (
    st.phase == PH_DRAIN ##1 st.phase == PH_IDLE);
  c_overflow: cover property ($rose(loadOverflow));
  c_kernel_entry: cover property (firstKernelBoundary);

endmodule : software_pipelined_loop_buffer

`default_nettype wire

// ==== rtl/stage_if.sv ====
// carrier between the controller and its stage timer
// assumes both ends share the core clock
`timescale 1ns/100ps
`default_nettype none

interface stage_if;
  import loop_buffer_pkg::*;
  logic              restart;
  logic              hold;
  logic [SLOT_W-1:0] ii;
  logic [SLOT_W-1:0] slot;
  logic              boundary;

  modport timer (input restart, input hold, input ii,
                 output slot, output boundary);
  modport ctrl  (output restart, output hold, output ii,
                 input slot, input boundary);
endinterface : stage_if

`default_nettype wire

// ==== tb/fetch_model.sv ====
// cpu fetch and execute side as seen by the loop buffer
// assumes the bench calls one task per core clock cycle
`timescale 1ns/100ps
`default_nettype none

module fetch_model
  import loop_buffer_pkg::*;
(
  input  wire logic                           clk,
  output var  logic                           startValid,
  output var  loop_buffer_pkg::loop_kind_type startKind,
  output var  logic [SLOT_W-1:0]              startIi,
  output var  logic                           fetchValid,
  output var  logic [PACKET_W-1:0]            fetchPacket,
  output var  logic                           kernelEnd,
  output var  logic                           stall,
  output var  logic                           countZero,
  output var  logic                           predicateZero
);
  logic czNext;
  logic pzNext;

  initial
  begin
    czNext        = 1'b0;
    pzNext        = 1'b0;
    startValid    = 1'b0;
    startKind     = KIND_COUNTED;
    startIi       = SLOT_ONE;
    fetchValid    = 1'b0;
    fetchPacket   = 32'h0;
    kernelEnd     = 1'b0;
    stall         = 1'b0;
    countZero     = 1'b0;
    predicateZero = 1'b0;
  end

  // ------------------------------------------------------------
  // loop start, one cycle wide
  // ------------------------------------------------------------
  task automatic start(input loop_kind_type kind,
                       input logic [SLOT_W-1:0] ii);
    @(negedge clk);
    startValid = 1'b1;
    startKind  = kind;
    startIi    = ii;
    fetchValid = 1'b0;
    kernelEnd  = 1'b0;
  endtask : start

  // ------------------------------------------------------------
  // one body or idle cycle
  // ------------------------------------------------------------
  // body ends on marker
  task automatic cyc(input logic fv, input logic [PACKET_W-1:0] pkt,
                     input logic ke, input logic st);
    @(negedge clk);
    startValid    = 1'b0;
    // interval is only sampled with start, so show garbage after
    startIi       = ~startIi;
    fetchValid    = fv;
    // an idle bus must not keep showing the last packet
    fetchPacket   = fv ? pkt : ~fetchPacket;
    kernelEnd     = ke;
    stall         = st;
    countZero     = czNext;
    predicateZero = pzNext;
    #1;
  endtask : cyc
endmodule : fetch_model

`default_nettype wire

// ==== tb/software_pipelined_loop_buffer_tb.sv ====
// self-checking bench of the loop buffer controller
// assumes fetch_model stands for the cpu fetch path
`timescale 1ns/100ps
`default_nettype none

module software_pipelined_loop_buffer_tb;
  import loop_buffer_pkg::*;

  typedef struct {
    int          id;
    logic [31:0] val;
  } note_type;

  typedef struct {
    int            len;
    logic          pk;
    logic          ke;
    logic          ovf;
    loop_kind_type kind;
  } case_type;

  logic                               clk;
  logic                               rstn;
  logic                               startValid;
  loop_kind_type                      startKind;
  logic [SLOT_W-1:0]                  startIi;
  logic                               fetchValid;
  logic [PACKET_W-1:0]                fetchPacket;
  logic                               kernelEnd;
  logic                               stall;
  logic                               countZero;
  logic                               predicateZero;
  logic                               memFetchEnable;
  logic [BUF_DEPTH-1:0]               bufIssueMask;
  logic [BUF_DEPTH-1:0][PACKET_W-1:0] bufPacket;
  logic [SLOT_W-1:0]                  slotIndex;
  logic                               stageBoundary;
  logic                               firstLoadBoundary;
  logic                               firstKernelBoundary;
  logic                               lastKernelBoundary;
  logic                               bufferActive;
  logic                               loadOverflow;
  logic [PACKET_W-1:0]                pA;
  logic [PACKET_W-1:0]                pB;
  logic [SLOT_W-1:0]                  ii;
  logic                               last;
  note_type                           notes [$];
  note_type                           note;
  event                               sampleEv;
  int                                 nBound;
  int                                 nMismatch = 0;
  int                                 checks = 0;
  string names [11] = '{"bufferActive", "slotIndex", "stageBoundary",
    "firstLoadBoundary", "firstKernelBoundary", "lastKernelBoundary",
    "memFetchEnable", "bufIssueMask", "loadOverflow", "bufPacket0",
    "boundaryCount"};
  case_type cases [4] = '{'{14, 1'b1, 1'b1, 1'b0, KIND_COUNTED},
    '{15, 1'b1, 1'b0, 1'b1, KIND_DELAYED},
    '{48, 1'b0, 1'b1, 1'b0, KIND_DELAYED},
    '{48, 1'b0, 1'b0, 1'b1, KIND_WHILE}};

  fetch_model i_fetch_model (
    .clk           (clk),
    .startValid    (startValid),
    .startKind     (startKind),
    .startIi       (startIi),
    .fetchValid    (fetchValid),
    .fetchPacket   (fetchPacket),
    .kernelEnd     (kernelEnd),
    .stall         (stall),
    .countZero     (countZero),
    .predicateZero (predicateZero)
  );

  software_pipelined_loop_buffer i_software_pipelined_loop_buffer (
    .clk                 (clk),
    .rstn                (rstn),
    .startValid          (startValid),
    .startKind           (startKind),
    .startIi             (startIi),
    .fetchValid          (fetchValid),
    .fetchPacket         (fetchPacket),
    .kernelEnd           (kernelEnd),
    .stall               (stall),
    .countZero           (countZero),
    .predicateZero       (predicateZero),
    .memFetchEnable      (memFetchEnable),
    .bufIssueMask        (bufIssueMask),
    .bufPacket           (bufPacket),
    .slotIndex           (slotIndex),
    .stageBoundary       (stageBoundary),
    .firstLoadBoundary   (firstLoadBoundary),
    .firstKernelBoundary (firstKernelBoundary),
    .lastKernelBoundary  (lastKernelBoundary),
    .bufferActive        (bufferActive),
    .loadOverflow        (loadOverflow)
  );

  // ------------------------------------------------------------
  // clock, notes and their checker
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] obs(input int id);
    case (id)
      0: obs = 32'(bufferActive);
      1: obs = 32'(slotIndex);
      2: obs = 32'(stageBoundary);
      3: obs = 32'(firstLoadBoundary);
      4: obs = 32'(firstKernelBoundary);
      5: obs = 32'(lastKernelBoundary);
      6: obs = 32'(memFetchEnable);
      7: obs = 32'(bufIssueMask);
      8: obs = 32'(loadOverflow);
      9: obs = bufPacket[0];
      default: obs = 32'(nBound);
    endcase
  endfunction : obs

  task automatic chk(input int id, input logic [31:0] val);
    notes.push_back('{id, val});
    -> sampleEv;
  endtask : chk

  // outputs are sampled a moment after the falling-edge drive
  always @(sampleEv)
  begin
    while (notes.size() > 0)
    begin
      note = notes.pop_front();
      checks++;
      if (obs(note.id) !== note.val)
      begin
        nMismatch++;
        $display("unexpected %s expected %0h seen %0h", names[note.id],
                 note.val, obs(note.id));
      end
    end
  end

  task automatic idle(input int n);
    repeat (n) i_fetch_model.cyc(1'b0, 32'h0, 1'b0, 1'b0);
  endtask : idle

  task automatic end_sim;
    #1;
    $display("checks %0d mismatches %0d", checks, nMismatch);
    if (nMismatch == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    rstn = 1'b0;
    void'($urandom(13));
    pA = $urandom();
    pB = $urandom();
    repeat (2) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    #1;
    chk(0, 32'h0);
    // counted loop, ii 1: packet, nop, marker packet
    i_fetch_model.start(KIND_COUNTED, SLOT_ONE);
    i_fetch_model.cyc(1'b1, pA, 1'b0, 1'b0);
    chk(0, 32'h1);
    chk(1, 32'h0);
    chk(3, 32'h1);
    chk(6, 32'h1);
    idle(1);
    chk(7, 32'h1);
    i_fetch_model.cyc(1'b1, pB, 1'b1, 1'b0);
    chk(4, 32'h1);
    i_fetch_model.cyc(1'b0, 32'h0, 1'b0, 1'b1);
    chk(7, 32'h0);
    chk(2, 32'h0);
    idle(1);
    chk(6, 32'h0);
    chk(7, 32'h3);
    chk(9, pA);
    i_fetch_model.czNext = 1'b1;
    idle(1);
    chk(5, 32'h1);
    idle(1);
    chk(7, 32'h2);
    idle(2);
    chk(7, 32'h0);
    chk(0, 32'h1);
    idle(1);
    chk(0, 32'h0);
    // while loop, ii 2, count already zero
    i_fetch_model.start(KIND_WHILE, 6'h02);
    i_fetch_model.cyc(1'b1, pA, 1'b0, 1'b0);
    chk(2, 32'h0);
    idle(1);
    chk(3, 32'h1);
    chk(1, 32'h1);
    i_fetch_model.cyc(1'b1, pB, 1'b1, 1'b0);
    chk(7, 32'h1);
    i_fetch_model.pzNext = 1'b1;
    idle(1);
    chk(4, 32'h1);
    idle(1);
    chk(7, 32'h3);
    idle(1);
    chk(5, 32'h0);
    chk(0, 32'h1);
    idle(2);
    chk(0, 32'h1);
    idle(1);
    chk(0, 32'h0);
    chk(7, 32'h0);
    i_fetch_model.pzNext = 1'b0;
    i_fetch_model.czNext = 1'b0;
    // capacity limits, every loop kind, random interval
    foreach (cases[c])
    begin
      // first case asks for interval 0, which must act as 1
      ii = (c == 0) ? 6'h00 : 6'($urandom_range(4, 1));
      nBound = 0;
      i_fetch_model.start(cases[c].kind, ii);
      for (int k = 1; k <= cases[c].len; k++)
      begin
        last = (k == cases[c].len);
        i_fetch_model.cyc(cases[c].pk | (last & cases[c].ke), $urandom(),
                          last & cases[c].ke, 1'b0);
        if (k <= 12 && stageBoundary === 1'b1)
          nBound++;
      end
      chk(10, 32'(12 / ((ii == 6'h00) ? 6'h01 : ii)));
      idle(2);
      chk(8, 32'(cases[c].ovf));
      chk(0, 32'(!cases[c].ovf));
      i_fetch_model.czNext = 1'b1;
      idle(64);
      chk(0, 32'h0);
      i_fetch_model.czNext = 1'b0;
    end
    end_sim();
  end

  initial
  begin
    #20000;
    nMismatch++;
    end_sim();
  end
endmodule : software_pipelined_loop_buffer_tb

`default_nettype wire
